/* rtl/crm_top.sv */
// Receive extended-id masks, buffer full/overflow flags and interrupt
// Function
// RL1: Three sixteen-bit read/write extended-id mask registers
// RL2: Mask one compares bit, zero is don't-care
// RL3: Filling buffer n sets its full flag
// RL4: Full flag zero means buffer empty, available
// RL5: Store into full buffer sets overflow flag
// RL6: Overflow zero means none since last clear
// RL7: Software clears flags by zero; one ignored
// RL8: Reset clears flags; masks left unknown
`timescale 1ns/1ns
`include "crm_defines.svh"
module crm_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port
  input wire crm_pkg::crm_bus_req_t bus_req,
  output logic [15:0] rdata,
  // Store path from the message store
  input wire crm_pkg::crm_store_t store,
  // Mask bits to the filter comparison
  output logic [3*16-1:0] ext_id_mask_bit,
  // Buffer state to the message store
  output logic [31:0] buffer_full_flag,
  output logic [31:0] buffer_overflow_flag,
  // Interrupt
  output logic irq
);
  import crm_pkg::*;

  logic [15:0] mask_q [`CRM_NUM_MASKS];
  logic [`CRM_NUM_BUFS-1:0] full_w;
  logic [`CRM_NUM_BUFS-1:0] ovf_w;
  logic [`CRM_NUM_BUFS-1:0] clr_full;
  logic [`CRM_NUM_BUFS-1:0] clr_ovf;
  logic [`CRM_NUM_BUFS-1:0] hit;
  logic [`CRM_IRQ_W-1:0] irq_stat_q;
  logic [`CRM_IRQ_W-1:0] irq_mask_q;
  logic [15:0] rdata_d;
  logic wr_full_lo;
  logic wr_full_hi;
  logic wr_ovf_lo;
  logic wr_ovf_hi;
  logic store_full;
  logic store_ovf;
  crm_rd_state_t rd_state_q;

  assign wr_full_lo = bus_req.wr && (bus_req.addr == `CRM_OFS_FULL_LO);
  assign wr_full_hi = bus_req.wr && (bus_req.addr == `CRM_OFS_FULL_HI);
  assign wr_ovf_lo = bus_req.wr && (bus_req.addr == `CRM_OFS_OVF_LO);
  assign wr_ovf_hi = bus_req.wr && (bus_req.addr == `CRM_OFS_OVF_HI);

  // Events for the interrupt: any store, and any store into a full buffer
  assign store_full = store.store;
  assign store_ovf = store.store && full_w[store.index];

  // Mask registers have no reset; software must load them before filtering
  always_ff @(posedge mclk) begin
    if (bus_req.wr && (bus_req.addr == `CRM_OFS_MASK0)) begin
      mask_q[0] <= bus_req.wdata; // [RL1]
    end
    if (bus_req.wr && (bus_req.addr == `CRM_OFS_MASK1)) begin
      mask_q[1] <= bus_req.wdata; // [RL1]
    end
    if (bus_req.wr && (bus_req.addr == `CRM_OFS_MASK2)) begin
      mask_q[2] <= bus_req.wdata; // [RL1] [RL8]
    end
  end

  // Per-buffer flag pairs; a zero in the written word clears that flag
  for (genvar i = 0; i < `CRM_NUM_BUFS; i++) begin : g_buf
    if (i < `CRM_HALF) begin : g_lo
      assign clr_full[i] = wr_full_lo && !bus_req.wdata[i]; // [RL7]
      assign clr_ovf[i] = wr_ovf_lo && !bus_req.wdata[i]; // [RL7]
    end else begin : g_hi
      assign clr_full[i] = wr_full_hi && !bus_req.wdata[i-`CRM_HALF]; // [RL7]
      assign clr_ovf[i] = wr_ovf_hi && !bus_req.wdata[i-`CRM_HALF]; // [RL7]
    end
    assign hit[i] = store.store && (store.index == 5'(i)); // [RL3]
    crm_flag_bit u_flag (
      .mclk(mclk),
      .nrst(nrst),
      .store_hit(hit[i]),
      .clr_full(clr_full[i]),
      .clr_ovf(clr_ovf[i]),
      .full_q(full_w[i]),
      .ovf_q(ovf_w[i])
    );
  end

  // Mask bits out, registered so the filter sees a flop output
  always_ff @(posedge mclk) begin
    ext_id_mask_bit <= {mask_q[2], mask_q[1], mask_q[0]}; // [RL2]
  end

  // Flag copies to the store path; one cycle behind the flag flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      buffer_full_flag <= `CRM_FLAGS_RST;
      buffer_overflow_flag <= `CRM_FLAGS_RST;
    end else begin
      buffer_full_flag <= full_w; // [RL4]
      buffer_overflow_flag <= ovf_w; // [RL6]
    end
  end

  // Interrupt status: set wins over write-one-to-clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_q <= `CRM_IRQ_RST;
    end else begin
      irq_stat_q[`CRM_IRQ_FULL] <= store_full || (irq_stat_q[`CRM_IRQ_FULL] &&
        !(bus_req.wr && (bus_req.addr == `CRM_OFS_IRQ_STAT) &&
          bus_req.wdata[`CRM_IRQ_FULL]));
      irq_stat_q[`CRM_IRQ_OVF] <= store_ovf || (irq_stat_q[`CRM_IRQ_OVF] &&
        !(bus_req.wr && (bus_req.addr == `CRM_OFS_IRQ_STAT) &&
          bus_req.wdata[`CRM_IRQ_OVF])); // [RL5]
    end
  end

  // Interrupt mask
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_mask_q <= `CRM_IRQ_RST;
    end else if (bus_req.wr && (bus_req.addr == `CRM_OFS_IRQ_MASK)) begin
      irq_mask_q <= bus_req.wdata[`CRM_IRQ_W-1:0];
    end
  end

  // Interrupt output lags status by one cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = `CRM_RD_ZERO;
    case (bus_req.addr)
      `CRM_OFS_MASK0: rdata_d = mask_q[0];
      `CRM_OFS_MASK1: rdata_d = mask_q[1];
      `CRM_OFS_MASK2: rdata_d = mask_q[2];
      `CRM_OFS_FULL_LO: rdata_d = full_w[`CRM_HALF-1:0]; // [RL4]
      `CRM_OFS_FULL_HI: rdata_d = full_w[`CRM_NUM_BUFS-1:`CRM_HALF];
      `CRM_OFS_OVF_LO: rdata_d = ovf_w[`CRM_HALF-1:0]; // [RL6]
      `CRM_OFS_OVF_HI: rdata_d = ovf_w[`CRM_NUM_BUFS-1:`CRM_HALF];
      `CRM_OFS_IRQ_STAT: rdata_d = {14'h0000, irq_stat_q};
      `CRM_OFS_IRQ_MASK: rdata_d = {14'h0000, irq_mask_q};
      default: rdata_d = `CRM_RD_ZERO;
    endcase
  end

  // Read data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata <= `CRM_RD_ZERO;
      rd_state_q <= CRM_RD_IDLE;
    end else begin
      case (bus_req.rd)
        1'b1: begin
          rdata <= rdata_d;
          rd_state_q <= CRM_RD_DATA;
        end
        default: begin
          rdata <= `CRM_RD_ZERO;
          rd_state_q <= CRM_RD_IDLE;
        end
      endcase
    end
  end
endmodule

/* rtl/crm_defines.svh */
// Register offsets, field sizes and reset values for the receive mask and status block
`ifndef CRM_DEFINES_SVH
`define CRM_DEFINES_SVH
`define CRM_ADDR_W 4
`define CRM_OFS_MASK0 4'h0
`define CRM_OFS_MASK1 4'h1
`define CRM_OFS_MASK2 4'h2
`define CRM_OFS_FULL_LO 4'h3
`define CRM_OFS_FULL_HI 4'h4
`define CRM_OFS_OVF_LO 4'h5
`define CRM_OFS_OVF_HI 4'h6
`define CRM_OFS_IRQ_STAT 4'h7
`define CRM_OFS_IRQ_MASK 4'h8
`define CRM_NUM_MASKS 3
`define CRM_NUM_BUFS 32
`define CRM_HALF 16
`define CRM_FLAGS_RST 32'h0000_0000
`define CRM_IRQ_RST 2'h0
`define CRM_RD_ZERO 16'h0000
`define CRM_IRQ_W 2
`define CRM_IRQ_FULL 0
`define CRM_IRQ_OVF 1
`endif

/* rtl/crm_pkg.sv */
// Types shared by the receive mask and status block
package crm_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } crm_bus_req_t;
  typedef struct packed {
    logic store;
    logic [4:0] index;
  } crm_store_t;
  typedef enum logic [1:0] {
    CRM_RD_IDLE = 2'b00,
    CRM_RD_DATA = 2'b01
  } crm_rd_state_t;
endpackage

/* rtl/crm_flag_bit.sv */
// One receive buffer's full and overflow flag pair
`timescale 1ns/1ns
module crm_flag_bit (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Store path
  input wire logic store_hit,
  // Software clears, active on a written zero
  input wire logic clr_full,
  input wire logic clr_ovf,
  // Flag state
  output logic full_q,
  output logic ovf_q
);
  // Full flag: set beats a same-cycle clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      full_q <= 1'b0; // [RL8]
    end else if (store_hit) begin
      full_q <= 1'b1; // [RL3]
    end else if (clr_full) begin
      full_q <= 1'b0; // [RL4] [RL7]
    end
  end

  // Overflow: storing into an already full buffer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ovf_q <= 1'b0; // [RL8]
    end else if (store_hit && full_q) begin
      ovf_q <= 1'b1; // [RL5]
    end else if (clr_ovf) begin
      ovf_q <= 1'b0; // [RL6] [RL7]
    end
  end
endmodule

/* verification/crm_store_model.sv */
// Message store stand-in that pulses buffer writes
`timescale 1ns/1ns
module crm_store_model (
  // Clock
  input wire logic mclk,
  // Store path
  output crm_pkg::crm_store_t store
);
  import crm_pkg::*;
  initial store = '0;
  // One-cycle store pulse, index left wandering once idle
  task automatic put(input logic [4:0] i);
    @(posedge mclk);
    store <= '{store: 1'b1, index: i};
    @(posedge mclk);
    store <= '{store: 1'b0, index: ~i};
  endtask
endmodule

/* verification/crm_top_sva.sv */
// Port checker for the receive mask and status block
`timescale 1ns/1ns
`include "crm_defines.svh"
module crm_top_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Watched ports
  input wire crm_pkg::crm_bus_req_t bus_req,
  input wire crm_pkg::crm_store_t store,
  input wire logic [3*16-1:0] ext_id_mask_bit,
  input wire logic [31:0] buffer_full_flag,
  input wire logic [31:0] buffer_overflow_flag
);
  import crm_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Port copies lag the register view by one cycle
  chk_full_set: assert property (
    store.store |=> ##1 buffer_full_flag[$past(store.index, 2)]) else $error("full not set");
  // Recent clear writes excluded: port may still show a cleared flag
  chk_ovf_set: assert property (
    store.store && buffer_full_flag[store.index] && !bus_req.wr && !$past(bus_req.wr)
    |=> ##1 buffer_overflow_flag[$past(store.index, 2)]) else $error("overflow not set");
  chk_full_rise: assert property (
    (buffer_full_flag & ~$past(buffer_full_flag)) != 0 |-> $past(store.store, 2))
    else $error("full rose without store");
  chk_ovf_rise: assert property (
    (buffer_overflow_flag & ~$past(buffer_overflow_flag)) != 0 |-> $past(store.store, 2))
    else $error("overflow rose without store");
  chk_full_fall: assert property (
    (~buffer_full_flag & $past(buffer_full_flag)) != 0 |-> $past(bus_req.wr, 2))
    else $error("full fell without write");
  chk_ovf_fall: assert property (
    (~buffer_overflow_flag & $past(buffer_overflow_flag)) != 0 |-> $past(bus_req.wr, 2))
    else $error("overflow fell without write");
  chk_mask_write: assert property (
    bus_req.wr && bus_req.addr == `CRM_OFS_MASK2 |-> ##2
    ext_id_mask_bit[47:32] == $past(bus_req.wdata, 2)) else $error("mask2 not written");
  chk_reset_flags: assert property (disable iff (1'b0)
    !nrst |-> buffer_full_flag == 32'h0 && buffer_overflow_flag == 32'h0)
    else $error("flags not cleared by reset");
  // Main scenarios
  cov_store: cover property (store.store);
  cov_overflow: cover property (store.store && buffer_full_flag[store.index]);
  cov_clear: cover property (bus_req.wr && bus_req.addr == `CRM_OFS_FULL_LO);
endmodule
bind crm_top crm_top_sva crm_top_sva_i (.mclk(mclk), .nrst(nrst), .bus_req(bus_req),
  .store(store), .ext_id_mask_bit(ext_id_mask_bit), .buffer_full_flag(buffer_full_flag),
  .buffer_overflow_flag(buffer_overflow_flag));

/* verification/testbench.sv */
// Self-checking bench for the receive mask and status block
`timescale 1ns/1ns
`include "crm_defines.svh"
module testbench;
  import crm_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b1;
  crm_bus_req_t bus_req = '0;
  crm_store_t store;
  logic [15:0] rdata;
  logic [47:0] mask;
  logic [31:0] full;
  logic [31:0] ovf;
  logic irq;
  logic [15:0] v;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // 25 MHz clock
  always #20 mclk = ~mclk;
  crm_top crm_top_i (.mclk(mclk), .nrst(nrst), .bus_req(bus_req), .rdata(rdata),
    .store(store), .ext_id_mask_bit(mask), .buffer_full_flag(full),
    .buffer_overflow_flag(ovf), .irq(irq));
  crm_store_model crm_store_model_i (.mclk(mclk), .store(store));
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Cycle ceiling against hangs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    // Drive the falling edge explicitly so the async reset branch really fires
    nrst <= 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    for (int a = 3; a < 7; a++) begin
      rd(a[3:0], v);
      chk("flags after reset", v, 16'h0000);
    end
    for (int m = 0; m < 3; m++) begin
      wr(m[3:0], 16'ha5c3 ^ m[15:0]);
      rd(m[3:0], v);
      chk("mask read", v, 16'ha5c3 ^ m[15:0]);
    end
    chk("mask port", mask, {16'ha5c1, 16'ha5c2, 16'ha5c3});
    crm_store_model_i.put(5'd5);
    crm_store_model_i.put(5'd20);
    crm_store_model_i.put(5'd5);
    rd(`CRM_OFS_FULL_LO, v);
    chk("full low", v, 16'h0020);
    rd(`CRM_OFS_FULL_HI, v);
    chk("full high", v, 16'h0010);
    rd(`CRM_OFS_OVF_LO, v);
    chk("overflow low", v, 16'h0020);
    rd(`CRM_OFS_OVF_HI, v);
    chk("overflow high", v, 16'h0000);
    rd(`CRM_OFS_IRQ_STAT, v);
    chk("irq status", v, 16'h0003);
    chk("overflow port", ovf, 32'h0000_0020);
    wr(`CRM_OFS_FULL_LO, 16'hffff);
    rd(`CRM_OFS_FULL_LO, v);
    chk("full after ones", v, 16'h0020);
    wr(`CRM_OFS_FULL_LO, 16'hffdf);
    wr(`CRM_OFS_OVF_LO, 16'h0000);
    rd(`CRM_OFS_FULL_LO, v);
    chk("full cleared", v, 16'h0000);
    rd(`CRM_OFS_OVF_LO, v);
    chk("overflow cleared", v, 16'h0000);
    chk("full port", full, 32'h0010_0000);
    chk("overflow port clear", ovf, 32'h0000_0000);
    wr(`CRM_OFS_FULL_HI, 16'h0000);
    rd(`CRM_OFS_FULL_HI, v);
    chk("full high cleared", v, 16'h0000);
    chk("irq masked", irq, 1'b0);
    wr(`CRM_OFS_IRQ_MASK, 16'h0001);
    repeat (2) @(posedge mclk);
    #1 chk("irq raised", irq, 1'b1);
    wr(`CRM_OFS_IRQ_STAT, 16'h0001);
    repeat (2) @(posedge mclk);
    #1 chk("irq cleared", irq, 1'b0);
    wr(`CRM_OFS_IRQ_MASK, 16'h0002);
    repeat (2) @(posedge mclk);
    #1 chk("irq overflow", irq, 1'b1);
    rd(`CRM_OFS_IRQ_MASK, v);
    chk("irq mask read", v, 16'h0002);
    rd(4'hf, v);
    chk("unmapped read", v, 16'h0000);
    summarize();
  end
endmodule
